//--- rtl/amp_fault_status_regs.sv
`timescale 1ns/1ps
module amp_fault_status_regs (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // serial host link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n_out,
    input wire logic [1:0] addr_sel_in,
    // latched fault events from protection
    input wire logic [3:0] offset_fault_in,
    input wire logic [3:0] overcurrent_shutdown_in,
    input wire logic [3:0] open_load_flag_in,
    input wire logic [3:0] shorted_load_flag_in,
    input wire logic [3:0] supply_short_flag_in,
    input wire logic [3:0] ground_short_flag_in,
    // live supply and thermal status
    input wire logic [2:0] thermal_warning_level_in,
    input wire logic thermal_shutdown_live_in,
    input wire logic pump_voltage_fault_live_in,
    input wire logic analog_supply_fault_live_in,
    input wire logic power_supply_low_live_in,
    input wire logic power_supply_high_live_in,
    // live channel states
    input wire logic [3:0] grounded_output_in,
    input wire logic [3:0] floating_output_in,
    input wire logic [3:0] silenced_state_in,
    input wire logic [3:0] playing_state_in
);

    // ==========================================================
    // helpers
    // a bit moves only once the second and third stage agree
    function automatic amp_status_pkg::sampled_s agree(
        input amp_status_pkg::sampled_s a,
        input amp_status_pkg::sampled_s b,
        input amp_status_pkg::sampled_s cur);
        agree = (b & ~(a ^ b)) | (cur & (a ^ b));
    endfunction

    function automatic logic warn_legal(input logic [2:0] code);
        warn_legal = (code == amp_status_pkg::WARN_NONE) ||
                     (code == amp_status_pkg::WARN_ANY) ||
                     (code == amp_status_pkg::WARN_LEVEL1) ||
                     (code == amp_status_pkg::WARN_LEVEL2) ||
                     (code == amp_status_pkg::WARN_LEVEL3);
    endfunction

    function automatic logic [7:0] reg_byte(
        input logic [7:0] ptr,
        input amp_status_pkg::fault_s f,
        input amp_status_pkg::live_s l);
        case (ptr)
            amp_status_pkg::REG_OFFSET_OVERCURRENT:
                reg_byte = {f.offset, f.overcurrent};
            amp_status_pkg::REG_LOAD_DIAG_LOW:
                reg_byte = {f.open_load[1], f.shorted_load[1],
                            f.supply_short[1], f.ground_short[1],
                            f.open_load[0], f.shorted_load[0],
                            f.supply_short[0], f.ground_short[0]};
            amp_status_pkg::REG_LOAD_DIAG_HIGH:
                reg_byte = {f.open_load[3], f.shorted_load[3],
                            f.supply_short[3], f.ground_short[3],
                            f.open_load[2], f.shorted_load[2],
                            f.supply_short[2], f.ground_short[2]};
            amp_status_pkg::REG_SUPPLY_THERMAL:
                reg_byte = {l.warn_level, l.shutdown, l.pump,
                            l.analog, l.supply_low, l.supply_high};
            amp_status_pkg::REG_OUTPUT_STATE:
                reg_byte = {l.grounded, l.floating};
            amp_status_pkg::REG_PLAY_MUTE:
                reg_byte = {l.silenced, l.playing};
            default:
                reg_byte = amp_status_pkg::UNMAPPED_READ;
        endcase
    endfunction

    // ==========================================================
    // state and edge detection
    amp_status_pkg::core_s q;
    amp_status_pkg::core_s next_q;
    amp_status_pkg::sampled_s raw;
    amp_status_pkg::sampled_s clean_next;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rd_byte;

    assign raw = {scl_in, sda_in,
                  offset_fault_in, overcurrent_shutdown_in,
                  open_load_flag_in, shorted_load_flag_in,
                  supply_short_flag_in, ground_short_flag_in,
                  thermal_warning_level_in, thermal_shutdown_live_in,
                  pump_voltage_fault_live_in, analog_supply_fault_live_in,
                  power_supply_low_live_in, power_supply_high_live_in,
                  grounded_output_in, floating_output_in,
                  silenced_state_in, playing_state_in};

    assign clean_next = agree(q.s2, q.s3, q.clean);
    assign scl_rise = clean_next.pins.scl & ~q.clean.pins.scl;
    assign scl_fall = ~clean_next.pins.scl & q.clean.pins.scl;
    // data edges only count while the clock line stays high
    assign start_seen = q.clean.pins.scl & clean_next.pins.scl &
                        q.clean.pins.sda & ~clean_next.pins.sda;
    assign stop_seen = q.clean.pins.scl & clean_next.pins.scl &
                       ~q.clean.pins.sda & clean_next.pins.sda;
    assign rd_byte = reg_byte(q.ptr, q.latched, q.live);

    // open drain: data is always low, the enable decides
    assign sda_out = 1'b0;
    assign sda_drive_n_out = ~q.sda_low;

    // ==========================================================
    // next state
    always_comb begin
        next_q = q;
        next_q.s1 = raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.clean = clean_next;

        // strap caught on the first edge after release
        if (!q.addr_taken) begin
            next_q.addr_sel = addr_sel_in;
            next_q.addr_taken = 1'b1;
        end

        // sticky: only a reset clears, bus writes never reach here
        next_q.latched = q.latched | q.clean.fault;

        // live fields follow the filtered inputs
        next_q.live = q.clean.live;
        // grounded field copies the filtered input as it is, gated by nothing else
        next_q.live.grounded = q.clean.live.grounded;
        // an illegal warning code is a glitch; hold the last good level
        if (!warn_legal(q.clean.live.warn_level)) begin
            next_q.live.warn_level = q.live.warn_level;
        end

        if (stop_seen) begin
            next_q.state = amp_status_pkg::ST_IDLE;
            next_q.sda_low = 1'b0;
        end else if (start_seen) begin
            // covers the repeated start between subaddress and read
            next_q.state = amp_status_pkg::ST_DEV_ADDR;
            next_q.bit_cnt = '0;
            next_q.byte_full = 1'b0;
            next_q.sda_low = 1'b0;
        end else begin
            unique case (q.state)
                amp_status_pkg::ST_IDLE, amp_status_pkg::ST_WAIT_STOP: begin
                    next_q.sda_low = 1'b0;
                end
                amp_status_pkg::ST_DEV_ADDR, amp_status_pkg::ST_SUB_ADDR,
                amp_status_pkg::ST_WR_DATA: begin
                    if (scl_rise) begin
                        next_q.shift = {q.shift[6:0], q.clean.pins.sda};
                        next_q.bit_cnt = q.bit_cnt + amp_status_pkg::BIT_STEP;
                        next_q.byte_full = (q.bit_cnt == amp_status_pkg::LAST_BIT);
                    end
                    if (scl_fall && q.byte_full) begin
                        next_q.byte_full = 1'b0;
                        if (q.state == amp_status_pkg::ST_DEV_ADDR) begin
                            if (q.shift[7:1] == {amp_status_pkg::DEV_ADDR_FIXED,
                                                 q.addr_sel}) begin
                                next_q.read_dir = q.shift[0];
                                next_q.sda_low = 1'b1;
                                next_q.state = amp_status_pkg::ST_ADDR_ACK;
                            end else begin
                                next_q.state = amp_status_pkg::ST_WAIT_STOP;
                            end
                        end else if (q.state == amp_status_pkg::ST_SUB_ADDR) begin
                            next_q.ptr = q.shift;
                            next_q.sda_low = 1'b1;
                            next_q.state = amp_status_pkg::ST_SUB_ACK;
                        end else begin
                            // data acknowledged but discarded
                            next_q.ptr = q.ptr + amp_status_pkg::PTR_STEP;
                            next_q.sda_low = 1'b1;
                            next_q.state = amp_status_pkg::ST_WR_ACK;
                        end
                    end
                end
                amp_status_pkg::ST_ADDR_ACK, amp_status_pkg::ST_SUB_ACK,
                amp_status_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        next_q.bit_cnt = '0;
                        if (q.state == amp_status_pkg::ST_ADDR_ACK && q.read_dir) begin
                            next_q.shift = rd_byte;
                            next_q.sda_low = ~rd_byte[7];
                            next_q.state = amp_status_pkg::ST_RD_DATA;
                        end else begin
                            next_q.sda_low = 1'b0;
                            next_q.state = (q.state == amp_status_pkg::ST_ADDR_ACK) ?
                                           amp_status_pkg::ST_SUB_ADDR :
                                           amp_status_pkg::ST_WR_DATA;
                        end
                    end
                end
                amp_status_pkg::ST_RD_DATA: begin
                    if (scl_rise) begin
                        next_q.bit_cnt = q.bit_cnt + amp_status_pkg::BIT_STEP;
                        next_q.byte_full = (q.bit_cnt == amp_status_pkg::LAST_BIT);
                    end
                    if (scl_fall) begin
                        if (q.byte_full) begin
                            next_q.byte_full = 1'b0;
                            next_q.sda_low = 1'b0;
                            next_q.ptr = q.ptr + amp_status_pkg::PTR_STEP;
                            next_q.state = amp_status_pkg::ST_RD_ACK;
                        end else begin
                            next_q.shift = {q.shift[6:0], 1'b0};
                            next_q.sda_low = ~q.shift[6];
                        end
                    end
                end
                amp_status_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (q.clean.pins.sda) begin
                            // not-acknowledge: host will close with stop
                            next_q.state = amp_status_pkg::ST_WAIT_STOP;
                        end else begin
                            next_q.byte_full = 1'b1;
                        end
                    end
                    if (scl_fall && q.byte_full) begin
                        next_q.byte_full = 1'b0;
                        next_q.bit_cnt = '0;
                        next_q.shift = rd_byte;
                        next_q.sda_low = ~rd_byte[7];
                        next_q.state = amp_status_pkg::ST_RD_DATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= amp_status_pkg::CORE_RESET;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // checks
    property p_offset_latch;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        q.clean.fault.offset[3] |=> q.latched.offset[3] ##1 q.latched.offset[3];
    endproperty
    a_offset_latch: assert property (p_offset_latch)
        else $error("offset event not latched");

    property p_overcurrent_hold;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(q.clean.fault.overcurrent[0]) |=> q.latched.overcurrent[0] [*4];
    endproperty
    a_overcurrent_hold: assert property (p_overcurrent_hold)
        else $error("overcurrent flag did not hold");

    property p_sticky;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        q.latched.open_load[1] |=> q.latched.open_load[1];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("latched flag cleared without reset");

    property p_write_ignored;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (q.state == amp_status_pkg::ST_WR_DATA) |=>
            ((q.latched & $past(q.latched)) == $past(q.latched));
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write changed a flag");

    property p_output_state_read;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (q.state == amp_status_pkg::ST_ADDR_ACK && q.read_dir && scl_fall &&
         q.ptr == amp_status_pkg::REG_OUTPUT_STATE) |=>
            (q.shift == {$past(q.live.grounded), $past(q.live.floating)});
    endproperty
    a_output_state_read: assert property (p_output_state_read)
        else $error("output state byte wrong");

    property p_read_step;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (q.state == amp_status_pkg::ST_RD_DATA && scl_fall && q.byte_full && !stop_seen
         && !start_seen) |=> (q.ptr == $past(q.ptr) + amp_status_pkg::PTR_STEP) &&
            (q.state == amp_status_pkg::ST_RD_ACK) && !q.sda_low;
    endproperty
    a_read_step: assert property (p_read_step)
        else $error("read address did not step");

    property p_nack_release;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (q.state == amp_status_pkg::ST_RD_ACK && scl_rise && q.clean.pins.sda &&
         !stop_seen && !start_seen) |=>
            (q.state == amp_status_pkg::ST_WAIT_STOP) ##1 !q.sda_low;
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("line held after not-acknowledge");

    property p_warn_legal;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !warn_legal(q.clean.live.warn_level) |=> (q.live.warn_level == $past(q.live.warn_level))
            && warn_legal(q.live.warn_level);
    endproperty
    a_warn_legal: assert property (p_warn_legal)
        else $error("illegal thermal warning code");

    property p_floating_follow;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        $changed(q.clean.live.floating) |=> (q.live.floating == $past(q.clean.live.floating));
    endproperty
    a_floating_follow: assert property (p_floating_follow)
        else $error("floating state not shown");

endmodule

//--- common/amp_status_pkg.sv
package amp_status_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_OFFSET_OVERCURRENT = 8'h01;
    localparam logic [7:0] REG_LOAD_DIAG_LOW = 8'h02;
    localparam logic [7:0] REG_LOAD_DIAG_HIGH = 8'h03;
    localparam logic [7:0] REG_SUPPLY_THERMAL = 8'h04;
    localparam logic [7:0] REG_OUTPUT_STATE = 8'h05;
    localparam logic [7:0] REG_PLAY_MUTE = 8'h06;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;

    // ==========================================================
    // serial link constants
    localparam logic [4:0] DEV_ADDR_FIXED = 5'h1b;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // ==========================================================
    // thermal warning codes
    localparam logic [2:0] WARN_NONE = 3'h0;
    localparam logic [2:0] WARN_ANY = 3'h1;
    localparam logic [2:0] WARN_LEVEL1 = 3'h3;
    localparam logic [2:0] WARN_LEVEL2 = 3'h5;
    localparam logic [2:0] WARN_LEVEL3 = 3'h7;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV_ADDR, ST_ADDR_ACK, ST_SUB_ADDR, ST_SUB_ACK,
        ST_WR_DATA, ST_WR_ACK, ST_RD_DATA, ST_RD_ACK, ST_WAIT_STOP
    } link_state_e;

    // index 3 is channel 4, index 0 is channel 1
    typedef struct packed {
        logic [3:0] offset;
        logic [3:0] overcurrent;
        logic [3:0] open_load;
        logic [3:0] shorted_load;
        logic [3:0] supply_short;
        logic [3:0] ground_short;
    } fault_s;

    typedef struct packed {
        logic [2:0] warn_level;
        logic shutdown;
        logic pump;
        logic analog;
        logic supply_low;
        logic supply_high;
        logic [3:0] grounded;
        logic [3:0] floating;
        logic [3:0] silenced;
        logic [3:0] playing;
    } live_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } pins_s;

    typedef struct packed {
        pins_s pins;
        fault_s fault;
        live_s live;
    } sampled_s;

    typedef struct packed {
        sampled_s s1;
        sampled_s s2;
        sampled_s s3;
        sampled_s clean;
        fault_s latched;
        live_s live;
        link_state_e state;
        logic [2:0] bit_cnt;
        logic byte_full;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic read_dir;
        logic sda_low;
        logic addr_taken;
        logic [1:0] addr_sel;
    } core_s;

    // ==========================================================
    // reset values
    localparam live_s LIVE_RESET = '{floating: 4'hf, default: '0};
    localparam sampled_s SAMPLED_RESET = '{pins: '{scl: 1'b1, sda: 1'b1},
                                           fault: '0, live: LIVE_RESET};
    localparam core_s CORE_RESET = '{s1: SAMPLED_RESET, s2: SAMPLED_RESET,
                                     s3: SAMPLED_RESET, clean: SAMPLED_RESET,
                                     live: LIVE_RESET, state: ST_IDLE,
                                     default: '0};

endpackage

//--- verification/serial_host.sv
`timescale 1ns/1ps
// ==========================================
// two-wire host model, bit-banged on the core clock
module serial_host (
    // clock
    input wire logic core_clk_in,
    // bus wire
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    logic [7:0] rd [8];
    logic acked;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        acked = 1'b1;
    end
    // ten-cycle phases stay well clear of the pin filter
    task automatic phase(input logic c, input logic d);
        @(posedge core_clk_in);
        scl_out <= c;
        sda_out <= d;
        repeat (9) @(posedge core_clk_in);
    endtask
    // data never moves in the same phase as the clock edge
    task automatic xfer(input logic d, output logic q);
        phase(1'b0, sda_out);
        phase(1'b0, d);
        phase(1'b1, d);
        q = sda_in;
    endtask
    task automatic start();
        phase(1'b0, sda_out);
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
    endtask
    task automatic stop();
        phase(1'b0, sda_out);
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask
    task automatic send(input logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xfer(b[i], q);
        end
        xfer(1'b1, q);
        acked = acked & ~q;
    endtask
    task automatic recv(input logic last, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, b[i]);
        end
        xfer(last, q);
    endtask
    task automatic read_regs(input logic [6:0] dev, input logic [7:0] sub, input int n);
        acked = 1'b1;
        start();
        send({dev, 1'b0});
        send(sub);
        start();
        send({dev, 1'b1});
        for (int k = 0; k < n; k++) begin
            recv(k == n - 1, rd[k]);
        end
        stop();
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d);
        acked = 1'b1;
        start();
        send({dev, 1'b0});
        send(sub);
        send(d);
        stop();
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    // ==========================================
    // signals
    localparam logic [1:0] SEL = 2'h2;
    localparam logic [6:0] DEV = {amp_status_pkg::DEV_ADDR_FIXED, SEL};
    localparam logic [2:0] CODES [5] = '{amp_status_pkg::WARN_NONE, amp_status_pkg::WARN_ANY,
        amp_status_pkg::WARN_LEVEL1, amp_status_pkg::WARN_LEVEL2, amp_status_pkg::WARN_LEVEL3};
    logic core_clk_in;
    logic reset_n_in;
    logic scl;
    logic sda_host;
    logic sda_out;
    logic sda_drive_n_out;
    logic sda_wire;
    logic [31:0] seed = 32'hae1e;
    logic [23:0] nf;
    logic [2:0] code;
    logic [2:0] warn_exp;
    amp_status_pkg::fault_s fin;
    amp_status_pkg::fault_s lat;
    amp_status_pkg::live_s lin;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    // pulled-up wire, low while either side pulls
    assign sda_wire = sda_host & (sda_drive_n_out | sda_out);
    amp_fault_status_regs uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_drive_n_out(sda_drive_n_out), .addr_sel_in(SEL),
        .offset_fault_in(fin.offset), .overcurrent_shutdown_in(fin.overcurrent),
        .open_load_flag_in(fin.open_load), .shorted_load_flag_in(fin.shorted_load),
        .supply_short_flag_in(fin.supply_short), .ground_short_flag_in(fin.ground_short),
        .thermal_warning_level_in(lin.warn_level), .thermal_shutdown_live_in(lin.shutdown),
        .pump_voltage_fault_live_in(lin.pump), .analog_supply_fault_live_in(lin.analog),
        .power_supply_low_live_in(lin.supply_low),
        .power_supply_high_live_in(lin.supply_high), .grounded_output_in(lin.grounded),
        .floating_output_in(lin.floating), .silenced_state_in(lin.silenced),
        .playing_state_in(lin.playing));
    serial_host host (.core_clk_in(core_clk_in), .sda_in(sda_wire), .scl_out(scl),
        .sda_out(sda_host));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [3:0] dg(input int c);
        return {lat.open_load[c], lat.shorted_load[c], lat.supply_short[c], lat.ground_short[c]};
    endfunction
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        case (a)
            8'h01: return {lat.offset, lat.overcurrent};
            8'h02: return {dg(1), dg(0)};
            8'h03: return {dg(3), dg(2)};
            8'h04: return {warn_exp, lin.shutdown, lin.pump, lin.analog,
                           lin.supply_low, lin.supply_high};
            8'h05: return {lin.grounded, lin.floating};
            8'h06: return {lin.silenced, lin.playing};
            default: return 8'h00;
        endcase
    endfunction
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic read_cmp(input logic [7:0] a, input int n);
        host.read_regs(DEV, a, n);
        check({7'h0, host.acked}, 8'h01);
        for (int k = 0; k < n; k++) begin
            check(host.rd[k], exp_reg(8'(a + k)));
        end
    endtask
    // bus traffic is slow, so the ceiling is generous
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            end_sim();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        reset_n_in = 1'b0;
        fin = '0;
        lat = '0;
        lin = '0;
        warn_exp = '0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (10) @(posedge core_clk_in);
        read_cmp(8'h00, 8);
        for (int it = 0; it < 10; it++) begin
            @(posedge core_clk_in);
            nf = 24'(rnd() & rnd());
            // odd passes drive an unused warning code: the last good level must stay
            code = (it % 2 == 1) ? 3'(2 * it) : CODES[(it / 2) % 5];
            if (code == 3'h0 || code[0]) begin
                warn_exp = code;
            end
            fin <= nf;
            lat = lat | nf;
            lin <= {code, 21'(rnd())};
            repeat (8) @(posedge core_clk_in);
            read_cmp(8'h01, 6);
        end
        read_cmp(8'h05, 2);
        @(posedge core_clk_in);
        fin <= '0;
        host.write_reg(DEV, 8'h01, 8'h00);
        host.write_reg(DEV, 8'h05, 8'hff);
        check({7'h0, host.acked}, 8'h01);
        read_cmp(8'h01, 6);
        host.read_regs(DEV ^ 7'h01, 8'h01, 1);
        check({7'h0, host.acked}, 8'h00);
        check(host.rd[0], 8'hff);
        @(posedge core_clk_in);
        reset_n_in <= 1'b0;
        lat = '0;
        warn_exp = '0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (10) @(posedge core_clk_in);
        read_cmp(8'h01, 4);
        end_sim();
    end
endmodule
